/* hdl/diag_pkg.sv */
package diag_pkg;

    localparam int NUM_PINS   = 10;
    localparam int DIAG_PINS  = 5;
    localparam int PIN_DIAG_CLOCK   = 0;
    localparam int PIN_PROBE_A      = 1;
    localparam int PIN_PROBE_B      = 2;
    localparam int PIN_SERIAL_IN    = 3;
    localparam int PIN_SERIAL_OUT   = 4;
    localparam int PIN_PRESET_CLEAR = 5;
    localparam int PIN_IO_CLOCK     = 6;
    localparam int PIN_HCLK         = 7;
    localparam int PIN_GCLK_FIRST   = 8;
    localparam int PIN_GCLK_SECOND  = 9;

    localparam int SEL_W      = 6;
    localparam int DIR_W      = 3;
    localparam int CMD_W      = 8;
    localparam int ADDR_W     = 12;

    localparam logic [ADDR_W-1:0] OFS_CTRL   = 12'h000;
    localparam logic [ADDR_W-1:0] OFS_STATUS = 12'h004;
    localparam logic [ADDR_W-1:0] OFS_DIR    = 12'h008;
    localparam logic [ADDR_W-1:0] OFS_OUT    = 12'h00c;
    localparam logic [ADDR_W-1:0] OFS_OE     = 12'h010;
    localparam logic [ADDR_W-1:0] OFS_IN     = 12'h014;

    localparam int CTRL_LOCK_BIT = 8;
    localparam int ST_MODE_BIT   = 0;
    localparam int ST_LOCK_BIT   = 1;
    localparam int ST_SEL_A_LSB  = 8;
    localparam int ST_SEL_B_LSB  = 16;

    localparam logic [31:0] RD_UNMAPPED = 32'h0000_0000;
    localparam logic [2:0]  CNT_LAST    = 3'h7;
    localparam logic [2:0]  CNT_STEP    = 3'h1;

    typedef enum logic [2:0] {DIR_UNUSED, DIR_INPUT, DIR_OUTPUT, DIR_TRISTATE, DIR_BIDIR} io_dir_t;
    typedef enum logic [1:0] {OP_NOP, OP_SEL_A, OP_SEL_B, OP_LOCK} diag_op_t;

    typedef struct packed {
        diag_op_t           op;
        logic [SEL_W-1:0]   node;
    } diag_cmd_t;

    typedef struct packed {
        logic preset_sets;
        logic gclk_second_used;
        logic gclk_first_used;
        logic hclk_used;
        logic io_clock_used;
        logic preset_used;
    } ctrl_t;

    localparam int CTRL_W = $bits(ctrl_t);

    typedef struct packed {
        logic io_clock;
        logic array_clock;
        logic gclk_first;
        logic gclk_second;
    } clk_net_t;

endpackage

/* hdl/diag_pin_ctrl.sv */
// Notes on behaviour
// - Mode high gives clock, probes and serial input their diagnostic functions.
// - Mode low makes every diagnostic pin an ordinary user I/O buffer.
// - In diagnostic mode the first probe drives its selected node live.
// - The second probe independently drives its own selected node.
// - A permanent lock stops both probes revealing any internal node.
// - With mode high, serial input data selects probes and sets the probe lock.
// - Serial output drives diagnostic data only with mode high, else user I/O.
// - Preset/clear input sets or clears all I/O registers together.
// - Without preset/clear use, that pin is general user I/O.
// - I/O clock input clocks every I/O register; otherwise pin is user I/O.
// - Array clock input clocks the sequential modules; otherwise user I/O.
// - Both global clocks are buffered into the clock network, or user I/O.
// - Each user pin is input, output, three-state or bidirectional.
// - Unused user pins stay high impedance.
// - Partner supplies the diagnostic clock while mode is high; else user I/O.
`timescale 1ns/1ns
module diag_pin_ctrl
    import diag_pkg::*;
#(
    parameter int NODE_COUNT = 64
) (
    input  wire logic                  pclk,
    input  wire logic                  presetn,
    input  wire logic [ADDR_W-1:0]     paddr,
    input  wire logic                  psel,
    input  wire logic                  penable,
    input  wire logic                  pwrite,
    input  wire logic [31:0]           pwdata,
    output logic      [31:0]           prdata,
    output logic                       pready,
    output logic                       pslverr,
    input  wire logic                  diag_clock_pin,
    input  wire logic                  diag_mode_pin,
    input  wire logic [NUM_PINS-1:0]   pin_in,
    output logic      [NUM_PINS-1:0]   pin_out,
    output logic      [NUM_PINS-1:0]   pin_oe,
    input  wire logic [NODE_COUNT-1:0] probe_nodes,
    output clk_net_t                   clk_nets
);

    logic [NUM_PINS-1:0]        pin_meta;
    logic [NUM_PINS-1:0]        pin_s;
    logic [NUM_PINS-1:0]        pin_s_d;
    logic                       mode_meta;
    logic                       mode_s;
    logic                       mode_meta_d;
    logic                       mode_d;
    logic [CMD_W-1:0]           shreg;
    logic [2:0]                 bit_cnt;
    logic [SEL_W-1:0]           sel_a_d;
    logic [SEL_W-1:0]           sel_b_d;
    logic                       lock_d;
    logic                       tgl_d;
    logic                       tgl_meta;
    logic                       tgl_s;
    logic                       tgl_s_d;
    logic                       echo_meta;
    logic                       echo_s;
    logic [SEL_W-1:0]           sel_a;
    logic [SEL_W-1:0]           sel_b;
    logic                       lock;
    ctrl_t                      ctrl;
    logic [NUM_PINS*DIR_W-1:0]  dir_cfg;
    logic [NUM_PINS-1:0]        user_out_cfg;
    logic [NUM_PINS-1:0]        user_oe_cfg;
    logic [NUM_PINS-1:0]        io_reg;
    logic [NUM_PINS-1:0]        next_pin_out;
    logic [NUM_PINS-1:0]        next_pin_oe;
    logic [31:0]                next_prdata;
    logic                       mapped;
    wire logic [NUM_PINS-1:0]   user_oe_eff;
    wire logic [NUM_PINS-1:0]   dedicated;
    wire logic                  apb_acc;
    wire logic                  wr_fire;
    wire logic                  io_clock_rise;
    wire logic                  preset_clear;
    wire logic                  mode_clr_n;
    wire diag_cmd_t             cmd;

    // Pin levels and mode, two flops before any pclk-domain logic
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_meta  <= '0;
            pin_s     <= '0;
            pin_s_d   <= '0;
            mode_meta <= 1'b0;
            mode_s    <= 1'b0;
        end else begin
            pin_meta  <= pin_in;
            pin_s     <= pin_meta;
            pin_s_d   <= pin_s;
            mode_meta <= diag_mode_pin;
            mode_s    <= mode_meta;
        end
    end

    // Partner's clock stops between frames, so mode low clears this sync at once
    assign mode_clr_n = presetn & diag_mode_pin;

    always_ff @(posedge diag_clock_pin or negedge mode_clr_n) begin
        if (!mode_clr_n) begin
            mode_meta_d <= 1'b0;
            mode_d      <= 1'b0;
        end else begin
            mode_meta_d <= diag_mode_pin;
            mode_d      <= mode_meta_d;
        end
    end

    assign cmd = diag_cmd_t'({shreg[CMD_W-2:0], pin_in[PIN_SERIAL_IN]});

    always_ff @(posedge diag_clock_pin or negedge presetn) begin
        if (!presetn) begin
            shreg   <= '0;
            bit_cnt <= '0;
        end else if (!mode_d) begin
            bit_cnt <= '0;
        end else begin
            shreg   <= {shreg[CMD_W-2:0], pin_in[PIN_SERIAL_IN]};
            bit_cnt <= bit_cnt + CNT_STEP;
        end
    end

    // Command words stay put for a whole byte, so the toggle alone crosses safely
    always_ff @(posedge diag_clock_pin or negedge presetn) begin
        if (!presetn) begin
            sel_a_d <= '0;
            sel_b_d <= '0;
            lock_d  <= 1'b0;
            tgl_d   <= 1'b0;
        end else if (mode_d && bit_cnt == CNT_LAST) begin
            tgl_d <= ~tgl_d;
            case (cmd.op)
                OP_SEL_A: sel_a_d <= cmd.node;
                OP_SEL_B: sel_b_d <= cmd.node;
                OP_LOCK:  lock_d  <= 1'b1;
                default:  ;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tgl_meta <= 1'b0;
            tgl_s    <= 1'b0;
            tgl_s_d  <= 1'b0;
            echo_meta <= 1'b0;
            echo_s    <= 1'b0;
        end else begin
            tgl_meta <= tgl_d;
            tgl_s    <= tgl_meta;
            tgl_s_d  <= tgl_s;
            echo_meta <= shreg[CMD_W-1];
            echo_s    <= echo_meta;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sel_a <= '0;
            sel_b <= '0;
        end else if (tgl_s != tgl_s_d) begin
            sel_a <= sel_a_d;
            sel_b <= sel_b_d;
        end
    end

    // Lock is cleared only by reset, standing in for a blown fuse
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lock <= 1'b0;
        end else if ((tgl_s != tgl_s_d && lock_d) || (wr_fire && paddr == OFS_CTRL && pwdata[CTRL_LOCK_BIT])) begin
            lock <= 1'b1;
        end
    end

    // APB slave, one wait state on every access
    assign apb_acc = psel & penable;
    assign wr_fire = apb_acc & pready & pwrite & mapped;

    always_comb begin
        next_prdata = RD_UNMAPPED;
        mapped      = 1'b1;
        case (paddr)
            OFS_CTRL: begin
                next_prdata[CTRL_W-1:0]    = ctrl;
                next_prdata[CTRL_LOCK_BIT] = lock;
            end
            OFS_STATUS: begin
                next_prdata[ST_MODE_BIT]                 = mode_s;
                next_prdata[ST_LOCK_BIT]                 = lock;
                next_prdata[ST_SEL_A_LSB +: SEL_W]       = sel_a;
                next_prdata[ST_SEL_B_LSB +: SEL_W]       = sel_b;
            end
            OFS_DIR: next_prdata[NUM_PINS*DIR_W-1:0] = dir_cfg;
            OFS_OUT: next_prdata[NUM_PINS-1:0]       = user_out_cfg;
            OFS_OE:  next_prdata[NUM_PINS-1:0]       = user_oe_cfg;
            OFS_IN:  next_prdata[NUM_PINS-1:0]       = pin_s;
            default: mapped = 1'b0;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= '0;
        end else begin
            pready  <= apb_acc & ~pready;
            pslverr <= apb_acc & ~pready & ~mapped;
            if (apb_acc && !pready) begin
                prdata <= next_prdata;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl         <= '0;
            dir_cfg      <= '0;
            user_out_cfg <= '0;
            user_oe_cfg  <= '0;
        end else if (wr_fire) begin
            case (paddr)
                OFS_CTRL: ctrl         <= ctrl_t'(pwdata[CTRL_W-1:0]);
                OFS_DIR:  dir_cfg      <= pwdata[NUM_PINS*DIR_W-1:0];
                OFS_OUT:  user_out_cfg <= pwdata[NUM_PINS-1:0];
                OFS_OE:   user_oe_cfg  <= pwdata[NUM_PINS-1:0];
                default:  ;
            endcase
        end
    end

    // Per-pin user buffer kind
    for (genvar gi = 0; gi < NUM_PINS; gi++) begin : g_pin
        io_dir_t dir;
        assign dir = io_dir_t'(dir_cfg[gi*DIR_W +: DIR_W]);
        // Codes above the bidirectional one fall back to high impedance
        assign user_oe_eff[gi] = (dir == DIR_OUTPUT) |
                                 (((dir == DIR_TRISTATE) | (dir == DIR_BIDIR)) & user_oe_cfg[gi]);
    end

    assign dedicated = {ctrl.gclk_second_used, ctrl.gclk_first_used, ctrl.hclk_used, ctrl.io_clock_used,
                        ctrl.preset_used, {DIAG_PINS{mode_s}}};

    // I/O registers
    assign io_clock_rise = pin_s[PIN_IO_CLOCK] & ~pin_s_d[PIN_IO_CLOCK];
    assign preset_clear  = ctrl.preset_used & pin_s[PIN_PRESET_CLEAR];

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            io_reg <= '0;
        end else if (preset_clear) begin
            io_reg <= ctrl.preset_sets ? '1 : '0;
        end else if (!ctrl.io_clock_used || io_clock_rise) begin
            io_reg <= user_out_cfg;
        end
    end

    // Clock networks are registered copies, never gated clocks
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            clk_nets <= '0;
        end else begin
            clk_nets.io_clock    <= ctrl.io_clock_used & pin_s[PIN_IO_CLOCK];
            clk_nets.array_clock <= ctrl.hclk_used & pin_s[PIN_HCLK];
            clk_nets.gclk_first  <= ctrl.gclk_first_used & pin_s[PIN_GCLK_FIRST];
            clk_nets.gclk_second <= ctrl.gclk_second_used & pin_s[PIN_GCLK_SECOND];
        end
    end

    // Pin drive
    always_comb begin
        next_pin_oe  = user_oe_eff & ~dedicated;
        next_pin_out = io_reg;
        if (mode_s) begin
            next_pin_oe[PIN_PROBE_A]     = 1'b1;
            next_pin_out[PIN_PROBE_A]    = ~lock & probe_nodes[sel_a];
            next_pin_oe[PIN_PROBE_B]     = 1'b1;
            next_pin_out[PIN_PROBE_B]    = ~lock & probe_nodes[sel_b];
            next_pin_oe[PIN_SERIAL_OUT]  = 1'b1;
            next_pin_out[PIN_SERIAL_OUT] = echo_s;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_out <= '0;
            pin_oe  <= '0;
        end else begin
            pin_out <= next_pin_out;
            pin_oe  <= next_pin_oe;
        end
    end

    a_probe_a_live: assert property (@(posedge pclk) disable iff (!presetn)
        (mode_s && !lock) |=> pin_oe[PIN_PROBE_A] && pin_out[PIN_PROBE_A] == $past(probe_nodes[sel_a]))
        else $error("probe a does not follow its node");

    a_probe_b_live: assert property (@(posedge pclk) disable iff (!presetn)
        (mode_s && !lock) |=> pin_oe[PIN_PROBE_B] && pin_out[PIN_PROBE_B] == $past(probe_nodes[sel_b]))
        else $error("probe b does not follow its node");

    a_lock_hides: assert property (@(posedge pclk) disable iff (!presetn)
        (lock && mode_s) |=> !pin_out[PIN_PROBE_A] && !pin_out[PIN_PROBE_B])
        else $error("locked probe reveals a node");

    a_lock_sticky: assert property (@(posedge pclk) disable iff (!presetn)
        lock |=> lock [*8])
        else $error("probe lock released");

    a_diag_drivers: assert property (@(posedge pclk) disable iff (!presetn)
        mode_s |=> !pin_oe[PIN_DIAG_CLOCK] && !pin_oe[PIN_SERIAL_IN] && pin_oe[PIN_SERIAL_OUT] &&
                   pin_out[PIN_SERIAL_OUT] == $past(echo_s))
        else $error("diagnostic pin drive wrong in mode high");

    a_user_mode: assert property (@(posedge pclk) disable iff (!presetn)
        !mode_s |=> pin_oe[DIAG_PINS-1:0] == $past(user_oe_eff[DIAG_PINS-1:0]) &&
                    pin_out[DIAG_PINS-1:0] == $past(io_reg[DIAG_PINS-1:0]))
        else $error("diagnostic pin not user io in mode low");

    a_unused_hiz: assert property (@(posedge pclk) disable iff (!presetn)
        (dir_cfg[PIN_PRESET_CLEAR*DIR_W +: DIR_W] == DIR_UNUSED) |=> !pin_oe[PIN_PRESET_CLEAR])
        else $error("unused pin driven");

    a_preset_all: assert property (@(posedge pclk) disable iff (!presetn)
        preset_clear |=> io_reg == {NUM_PINS{$past(ctrl.preset_sets)}})
        else $error("io registers not preset or cleared together");

    a_io_clock_hold: assert property (@(posedge pclk) disable iff (!presetn)
        (ctrl.io_clock_used && !io_clock_rise && !preset_clear) |=> $stable(io_reg))
        else $error("io register changed without io clock edge");

    a_gclk_buffer: assert property (@(posedge pclk) disable iff (!presetn)
        ctrl.gclk_first_used |=> clk_nets.gclk_first == $past(pin_s[PIN_GCLK_FIRST]))
        else $error("global clock network not fed from pin");

    a_array_clock: assert property (@(posedge pclk) disable iff (!presetn)
        !ctrl.hclk_used |=> !clk_nets.array_clock)
        else $error("array clock active while pin is user io");

    a_cmd_taken: assert property (@(posedge diag_clock_pin) disable iff (!presetn)
        (mode_d && bit_cnt == CNT_LAST) |=> tgl_d != $past(tgl_d) && bit_cnt == '0)
        else $error("serial command not accepted");

    a_apb_wait: assert property (@(posedge pclk) disable iff (!presetn)
        (apb_acc && !pready) |=> pready)
        else $error("apb access not answered");

endmodule

/* sim/probe_host.sv */
`timescale 1ns/1ns
module probe_host (
    output logic mode,
    output logic diag_clock_pin,
    output logic diag_serial_in
);
    initial begin
        mode           = 1'b0;
        diag_clock_pin = 1'b0;
        diag_serial_in = 1'b1;
    end

    // Clock runs only inside frames, so the device never sees stray shifts
    task automatic tick(input logic b);
        diag_serial_in = b;
        #40 diag_clock_pin = 1'b1;
        #20 diag_serial_in = ~b; // Inverted line shows no stale bit
        #20 diag_clock_pin = 1'b0;
    endtask

    // Two lead-in clocks let the device's mode synchroniser settle
    task automatic enter();
        mode = 1'b1;
        #13;
        tick(1'b0);
        tick(1'b0);
    endtask

    task automatic send(input logic [7:0] cmd);
        for (int i = 7; i >= 0; i--) begin
            tick(cmd[i]);
        end
    endtask

    task automatic leave();
        mode = 1'b0;
        #13;
    endtask
endmodule

/* sim/testbench.sv */
`timescale 1ns/1ns
`define CHK(got, exp) begin cmp_count++; if ((got) !== (exp)) begin err_total++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp); end end
module testbench;
    import diag_pkg::*;
    logic              pclk;
    logic              presetn;
    logic [ADDR_W-1:0] paddr;
    logic              psel;
    logic              penable;
    logic              pwrite;
    logic [31:0]       pwdata;
    logic [31:0]       prdata;
    logic              pready;
    logic              pslverr;
    logic              mode;
    logic              diag_clock_pin;
    logic              diag_serial_in;
    logic [9:0]        pin_drv;
    logic [9:0]        pin_out;
    logic [9:0]        pin_oe;
    logic [63:0]       probe_nodes;
    clk_net_t          clk_nets;
    logic [31:0]       rdat;
    logic              rerr;
    int                err_total;
    int                cmp_count;

    wire [9:0] pin_in = {pin_drv[9:4], diag_serial_in, pin_drv[2:1], diag_clock_pin};

    diag_pin_ctrl uut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
        .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .diag_clock_pin(diag_clock_pin), .diag_mode_pin(mode), .pin_in(pin_in), .pin_out(pin_out),
        .pin_oe(pin_oe), .probe_nodes(probe_nodes), .clk_nets(clk_nets));

    probe_host host (.mode(mode), .diag_clock_pin(diag_clock_pin), .diag_serial_in(diag_serial_in));

    initial begin
        pclk = 1'b0;
        forever #4 pclk = ~pclk;
    end

    task automatic tally_and_finish();
        if (err_total == 0 && cmp_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
        int n;
        n = 0;
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50) begin
            err_total++;
            tally_and_finish();
        end
        rdat = prdata;
        rerr = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    // Fixed waits cover the two-flop sync plus the output register
    task automatic settle(input int n);
        repeat (n) @(posedge pclk);
    endtask

    task automatic t_reset();
        `CHK(pin_oe, 10'h000)
        apb(1'b0, OFS_CTRL, 32'h0);
        `CHK(rdat, 32'h0000_0000)
        apb(1'b0, 12'h020, 32'h0);
        `CHK({rerr, rdat}, {1'b1, RD_UNMAPPED})
    endtask

    task automatic t_user();
        logic [2:0]  dirs [10];
        logic [31:0] dw;
        dirs = '{DIR_OUTPUT, DIR_TRISTATE, DIR_BIDIR, DIR_INPUT, DIR_UNUSED,
                 DIR_OUTPUT, DIR_OUTPUT, DIR_OUTPUT, DIR_OUTPUT, DIR_OUTPUT};
        dw = 32'h0;
        for (int i = 0; i < 10; i++) begin
            dw[3*i +: 3] = dirs[i];
        end
        pin_drv <= 10'h0a4;
        apb(1'b1, OFS_DIR, dw);
        apb(1'b1, OFS_OE, 32'h0000_0002);
        apb(1'b1, OFS_OUT, 32'h0000_02a5);
        settle(6);
        `CHK(pin_oe, 10'h3e3)
        `CHK(pin_out & pin_oe, 10'h2a5 & 10'h3e3)
        apb(1'b0, OFS_IN, 32'h0);
        `CHK(rdat[9:0], 10'h0ac)
    endtask

    task automatic t_mode();
        host.enter();
        settle(6);
        `CHK(pin_oe[4:0], 5'b10110)
        probe_nodes <= 64'h0000_0000_0000_0020;
        host.send({2'h1, 6'd5});
        host.send({2'h2, 6'd40});
        settle(8);
        `CHK(pin_out[2:1], 2'b01)
        `CHK(pin_out[PIN_SERIAL_OUT], 1'b1)
        probe_nodes <= 64'h0000_0100_0000_0000;
        settle(3);
        `CHK(pin_out[2:1], 2'b10)
        apb(1'b0, OFS_STATUS, 32'h0);
        `CHK(rdat, 32'h0028_0501)
        `CHK(rdat[ST_MODE_BIT], 1'b1)
        host.leave();
        settle(6);
        `CHK(pin_oe, 10'h3e3)
        `CHK(pin_oe[PIN_SERIAL_OUT], 1'b0)
    endtask

    task automatic t_clocks();
        pin_drv <= 10'h3c0;
        apb(1'b1, OFS_CTRL, 32'h0000_001f);
        settle(6);
        `CHK(clk_nets.array_clock, 1'b1)
        `CHK({clk_nets.gclk_first, clk_nets.gclk_second}, 2'b11)
        `CHK(pin_oe[9:5], 5'b00000)
        apb(1'b1, OFS_CTRL, 32'h0000_003f);
        pin_drv <= 10'h3e0;
        settle(6);
        `CHK(pin_out[1:0], 2'b11)
        apb(1'b1, OFS_CTRL, 32'h0000_001f);
        settle(6);
        `CHK(pin_out[1:0], 2'b00)
        pin_drv <= 10'h000;
        apb(1'b1, OFS_CTRL, 32'h0000_0002);
        apb(1'b1, OFS_OUT, 32'h0000_03ff);
        settle(6);
        `CHK(pin_out[1:0], 2'b00)
        pin_drv <= 10'h040;
        settle(6);
        `CHK(pin_out[1:0], 2'b11)
        `CHK(clk_nets, 4'h8)
    endtask

    task automatic t_lock();
        host.enter();
        settle(1);
        probe_nodes <= '1;
        host.send({2'h3, 6'd0});
        settle(8);
        `CHK(pin_out[2:1], 2'b00)
        apb(1'b1, OFS_CTRL, 32'h0000_0000);
        apb(1'b0, OFS_STATUS, 32'h0);
        `CHK(rdat[ST_LOCK_BIT], 1'b1)
        host.leave();
    endtask

    initial begin
        presetn     = 1'b0;
        psel        = 1'b0;
        penable     = 1'b0;
        pwrite      = 1'b0;
        paddr       = '0;
        pwdata      = '0;
        pin_drv     = '0;
        probe_nodes = '0;
        err_total   = 0;
        cmp_count   = 0;
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        settle(2);
        t_reset();
        t_user();
        t_mode();
        t_clocks();
        t_lock();
        tally_and_finish();
    end
endmodule
